/* include/lmc_pkg.sv */
// Shared constants and types for the mode and lock control.
package lmc_pkg;

  // Synchroniser depth for non-synchronous pins.
  localparam int SYNC_STAGES = 2;

  // Reset values of the flops.
  localparam logic RST_LVL = 1'h0;

  // Processing modes of the datapath.
  typedef enum logic [1:0]
  {
    LMC_MODE_THROUGH = 2'h0,
    LMC_MODE_VIDEO   = 2'h1,
    LMC_MODE_ASYNC   = 2'h3
  } lmc_mode_t;

  // Controller state, Gray coded along slave -> master -> locked.
  typedef enum logic [1:0]
  {
    LMC_ST_SLAVE  = 2'h0,
    LMC_ST_MASTER = 2'h1,
    LMC_ST_LOCKED = 2'h3
  } lmc_state_t;

  // Decodes the processing mode from the async-serial and video-select bits.
  function automatic lmc_mode_t lmc_decode_mode(input logic async_bit,
                                                input logic video_bit);
    if (async_bit)
      lmc_decode_mode = LMC_MODE_ASYNC;
    else if (video_bit)
      lmc_decode_mode = LMC_MODE_VIDEO;
    else
      lmc_decode_mode = LMC_MODE_THROUGH;
  endfunction

endpackage

/* hw/lmc_sync.sv */
// Two-flop synchroniser for a non-synchronous level.
`timescale 1ns/1ps
module lmc_sync
  import lmc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_ff;
  logic hold_ff;

  // The first flop feeds only the second one.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_ff <= RST_LVL;
      hold_ff <= RST_LVL;
    end
    else
    begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
    end
  end

  assign sync_out = hold_ff;

endmodule

/* hw/lmc_ctrl.sv */
// Mode selection, loop-through reclock selection and lock indication.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Reclock select is an input in slave operation, driven output in master.
// [R2] Master: drive reclock select high only when locked to compliant stream.
// [R3] Master: non-compliant input drives reclock select low, buffered output.
// [R4] Slave with reclock select high: reclocked loop-through in every mode.
// [R5] Slave with reclock select low: buffered loop-through in every mode.
// [R6] Master select high: mode pins become status outputs, auto-detection.
// [R7] Master select low: mode pins are control inputs, never driven.
// [R8] Host sets slave-mode pins to match the incoming stream type.
// [R9] Slave operation reclocks and deserializes non-compliant data too.
// [R10] Lock output high when locked to compliant data or reclocker locked; the code takes reclocker lock alone only in data-through mode.
// [R11] Master select and reclock select inputs pass a two-stage synchroniser.
module lmc_ctrl
  import lmc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Operating mode strap
  input  wire logic master_select_in,
  // Reclock select pin
  input  wire logic reclock_select_in,
  output logic      reclock_select_out,
  output logic      reclock_select_oe_out,
  // Async serial mode pin
  input  wire logic async_serial_mode_pin_in,
  output logic      async_serial_mode_pin_out,
  output logic      async_serial_mode_pin_oe_out,
  // Rate select pin
  input  wire logic rate_select_pin_in,
  output logic      rate_select_pin_out,
  output logic      rate_select_pin_oe_out,
  // Video processing select pin
  input  wire logic video_processing_select_in,
  output logic      video_processing_select_out,
  output logic      video_processing_select_oe_out,
  // Status from the datapath and the reclocker
  input  wire logic reclocker_lock_in,
  input  wire logic video_compliant_in,
  input  wire logic async_compliant_in,
  input  wire logic detected_hd_in,
  // Controls towards the datapath
  output logic      loop_reclocked_out,
  output logic      auto_detect_out,
  output logic      deser_enable_out,
  output logic [1:0] proc_mode_out,
  output logic      rate_hd_out,
  // Lock status
  output logic      locked_out
);

  logic       master_s;
  logic       reclock_s;
  logic       compliant;
  lmc_mode_t  mode_now;
  lmc_state_t state_ff;
  lmc_state_t nxt_state;
  logic       rc_ff;
  logic       async_ff;
  logic       video_ff;
  logic       rate_ff;
  logic       loop_ff;
  logic [1:0] mode_ff;
  logic       lock_ff;
  logic       hd_ff;

  // The strap and the slave-mode reclock pin are asynchronous to the clock.
  lmc_sync u_sync_master
  (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (master_select_in),
    .sync_out   (master_s)
  ); // [R11]

  lmc_sync u_sync_reclock
  (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (reclock_select_in),
    .sync_out   (reclock_s)
  ); // [R11]

  // In master operation a stream is compliant when the reclocker is locked and video or async is found.
  assign compliant = reclocker_lock_in &
                     (video_compliant_in | async_compliant_in);

  // Slave operation takes the mode from the host pins; master from detection.
  always_comb
  begin
    if (state_ff == LMC_ST_SLAVE)
      mode_now = lmc_decode_mode(async_serial_mode_pin_in,
                                 video_processing_select_in); // [R8]
    else
      mode_now = lmc_decode_mode(async_compliant_in,
                                 video_compliant_in); // [R6]
  end

  always_comb
  begin
    case (state_ff)
      LMC_ST_SLAVE:
        nxt_state = master_s ? LMC_ST_MASTER : LMC_ST_SLAVE;
      LMC_ST_MASTER:
        if (!master_s)
          nxt_state = LMC_ST_SLAVE;
        else if (compliant)
          nxt_state = LMC_ST_LOCKED;
        else
          nxt_state = LMC_ST_MASTER;
      LMC_ST_LOCKED:
        if (!master_s)
          nxt_state = LMC_ST_SLAVE;
        else if (!compliant)
          nxt_state = LMC_ST_MASTER;
        else
          nxt_state = LMC_ST_LOCKED;
      default:
        nxt_state = LMC_ST_SLAVE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      state_ff <= LMC_ST_SLAVE;
    else
      state_ff <= nxt_state;
  end

  // Status values driven on the mode pins in master operation.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rc_ff    <= RST_LVL;
      async_ff <= RST_LVL;
      video_ff <= RST_LVL;
      rate_ff  <= RST_LVL;
    end
    else
    begin
      rc_ff    <= (nxt_state == LMC_ST_LOCKED); // [R2] [R3]
      async_ff <= (nxt_state == LMC_ST_LOCKED) & async_compliant_in; // [R6]
      video_ff <= (nxt_state == LMC_ST_LOCKED) & video_compliant_in; // [R6]
      // The rate pin reads high for SD in both directions, so invert here.
      rate_ff  <= ~detected_hd_in; // [R6]
    end
  end

  // Loop-through choice: lock state in master, host pin in slave.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      loop_ff <= RST_LVL;
    else if (nxt_state == LMC_ST_SLAVE)
      loop_ff <= reclock_s; // [R4] [R5]
    else
      loop_ff <= (nxt_state == LMC_ST_LOCKED); // [R2] [R3]
  end

  // HD indication towards the datapath: host pin in slave, detection in master.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      hd_ff <= RST_LVL;
    else if (nxt_state == LMC_ST_SLAVE)
      hd_ff <= ~rate_select_pin_in; // [R8]
    else
      hd_ff <= detected_hd_in; // [R6]
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      mode_ff <= LMC_MODE_THROUGH;
    else
      mode_ff <= mode_now;
  end

  // Data-through only needs the reclocker; other modes need compliance.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      lock_ff <= RST_LVL;
    else
      case (mode_now)
        LMC_MODE_THROUGH: lock_ff <= reclocker_lock_in; // [R10]
        LMC_MODE_VIDEO:   lock_ff <= reclocker_lock_in & video_compliant_in;
        LMC_MODE_ASYNC:   lock_ff <= reclocker_lock_in & async_compliant_in;
        default:          lock_ff <= RST_LVL;
      endcase
  end

  // Pins are driven only while master operation is in effect.
  always_comb
  begin
    reclock_select_oe_out          = (state_ff != LMC_ST_SLAVE); // [R1] [R7]
    async_serial_mode_pin_oe_out   = (state_ff != LMC_ST_SLAVE); // [R6] [R7]
    rate_select_pin_oe_out         = (state_ff != LMC_ST_SLAVE);
    video_processing_select_oe_out = (state_ff != LMC_ST_SLAVE);
  end

  assign reclock_select_out          = rc_ff;
  assign async_serial_mode_pin_out   = async_ff;
  assign rate_select_pin_out         = rate_ff;
  assign video_processing_select_out = video_ff;
  assign loop_reclocked_out          = loop_ff;
  assign proc_mode_out               = mode_ff;
  assign locked_out                  = lock_ff;
  // Auto-detection runs in master; deserialising runs always, even for
  // non-compliant data in slave operation.
  assign auto_detect_out  = (state_ff != LMC_ST_SLAVE); // [R6]
  assign deser_enable_out = 1'h1; // [R9]
  assign rate_hd_out      = hd_ff;

  // Assertions.
  a_oe_follows_mode: assert property ( // [R1]
    @(posedge clk_sys_in) disable iff (rst_in)
    !$past(master_s) |-> !reclock_select_oe_out)
    else $error("reclock pin driven in slave operation");
  a_rc_high_locked: assert property ( // [R2]
    @(posedge clk_sys_in) disable iff (rst_in)
    reclock_select_out |-> $past(master_s && compliant))
    else $error("reclock select high without lock in master operation");
  a_rc_low_nolock: assert property ( // [R3]
    @(posedge clk_sys_in) disable iff (rst_in)
    (master_s && state_ff != LMC_ST_SLAVE && !compliant) |=> !rc_ff)
    else $error("reclock select high on non-compliant input");
  a_slave_reclock: assert property ( // [R4]
    @(posedge clk_sys_in) disable iff (rst_in)
    (!master_s && state_ff == LMC_ST_SLAVE && reclock_s) |=> loop_ff)
    else $error("slave reclock high did not give reclocked output");
  a_slave_buffer: assert property ( // [R5]
    @(posedge clk_sys_in) disable iff (rst_in)
    (!master_s && state_ff == LMC_ST_SLAVE && !reclock_s) |=> !loop_ff)
    else $error("slave reclock low did not give buffered output");
  a_master_drives: assert property ( // [R6]
    @(posedge clk_sys_in) disable iff (rst_in)
    master_s |=> async_serial_mode_pin_oe_out)
    else $error("mode pins not driven in master operation");
  a_slave_quiet: assert property ( // [R7]
    @(posedge clk_sys_in) disable iff (rst_in)
    !master_s ##1 !master_s |=> !video_processing_select_oe_out)
    else $error("mode pins driven in slave operation");
  a_lock_through: assert property ( // [R10]
    @(posedge clk_sys_in) disable iff (rst_in)
    (mode_now == LMC_MODE_THROUGH) |=>
      locked_out == $past(reclocker_lock_in))
    else $error("lock output wrong in data-through mode");
  a_lock_video: assert property ( // [R10]
    @(posedge clk_sys_in) disable iff (rst_in)
    (mode_now == LMC_MODE_VIDEO) |=>
      locked_out == $past(reclocker_lock_in && video_compliant_in))
    else $error("lock output wrong in video mode");

endmodule

/* testbench/lmc_host_model.sv */
// Host logic model that drives the mode pins whenever the device does not.
`timescale 1ns/1ps
module lmc_host_model
(
  // Host levels, bit 0 reclock, 1 async, 2 rate, 3 video
  input  wire logic [3:0] host_val_in,
  // Device side of the same pins
  input  wire logic [3:0] dev_val_in,
  input  wire logic [3:0] dev_oe_in,
  // Resolved pin levels
  output logic      [3:0] pin_out
);
  // The host backs off on each pin that the device drives, so no contention.
  always_comb
    for (int i = 0; i < 4; i++)
      pin_out[i] = dev_oe_in[i] ? dev_val_in[i] : host_val_in[i];
endmodule

/* testbench/lmc_ctrl_test.sv */
// Self-checking bench for the mode, reclock select and lock control.
`timescale 1ns/1ps
module lmc_ctrl_test
  import lmc_pkg::*;
;
  logic       clk_sys_in  = 1'b0;
  logic       rst_in      = 1'b1;
  logic       ms          = 1'b0;
  logic [3:0] hv          = 4'h0;
  logic [3:0] st          = 4'h0;
  logic [3:0] h;
  logic [3:0] pin;
  logic [3:0] dv;
  logic [3:0] oe;
  logic       loop;
  logic       auto;
  logic       deser;
  logic       rate_hd;
  logic       locked;
  logic [1:0] pm;
  int         err_total   = 0;
  int         check_count = 0;
  lmc_mode_t  md[3]       = '{LMC_MODE_THROUGH, LMC_MODE_VIDEO,
                              LMC_MODE_ASYNC};

  always #5 clk_sys_in = ~clk_sys_in;

  lmc_host_model lmc_host_model_inst
  (
    .host_val_in (hv),
    .dev_val_in  (dv),
    .dev_oe_in   (oe),
    .pin_out     (pin)
  );

  lmc_ctrl lmc_ctrl_inst
  (
    .clk_sys_in                     (clk_sys_in),
    .rst_in                         (rst_in),
    .master_select_in               (ms),
    .reclock_select_in              (pin[0]),
    .reclock_select_out             (dv[0]),
    .reclock_select_oe_out          (oe[0]),
    .async_serial_mode_pin_in       (pin[1]),
    .async_serial_mode_pin_out      (dv[1]),
    .async_serial_mode_pin_oe_out   (oe[1]),
    .rate_select_pin_in             (pin[2]),
    .rate_select_pin_out            (dv[2]),
    .rate_select_pin_oe_out         (oe[2]),
    .video_processing_select_in     (pin[3]),
    .video_processing_select_out    (dv[3]),
    .video_processing_select_oe_out (oe[3]),
    .reclocker_lock_in              (st[3]),
    .video_compliant_in             (st[2]),
    .async_compliant_in             (st[1]),
    .detected_hd_in                 (st[0]),
    .loop_reclocked_out             (loop),
    .auto_detect_out                (auto),
    .deser_enable_out               (deser),
    .proc_mode_out                  (pm),
    .rate_hd_out                    (rate_hd),
    .locked_out                     (locked)
  );

  task automatic check(input string nm, input logic [3:0] seen,
                       input logic [3:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk1(input string nm, input logic seen, input logic exp);
    check(nm, {3'h0, seen}, {3'h0, exp});
  endtask

  // Four falling edges cover the two synchroniser flops, the state flop and the output flops.
  task automatic apply(input logic m, input logic [3:0] hh,
                       input logic [3:0] s);
    @(negedge clk_sys_in);
    ms = m;
    hv = hh;
    st = s;
    repeat (4) @(negedge clk_sys_in);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (2000) @(posedge clk_sys_in);
    err_total++;
    finish_test();
  end

  initial
  begin
    repeat (5) @(negedge clk_sys_in);
    rst_in = 1'b0;
    check("oe", oe, 4'h0);
    chk1("locked", locked, 1'b0);
    for (int r = 0; r < 2; r++)
      for (int k = 0; k < 3; k++)
      begin
        h = {k == 1, r[0], k == 2, r[0]};
        apply(1'b0, h, 4'h8);
        check("oe", oe, 4'h0);
        chk1("loop", loop, r[0]);
        check("mode", {2'h0, pm}, {2'h0, md[k]});
        chk1("locked", locked, k == 0);
        chk1("rate_hd", rate_hd, ~r[0]);
        chk1("deser", deser, 1'b1);
      end
    apply(1'b0, 4'h8, 4'hC);
    chk1("locked", locked, 1'b1);
    apply(1'b1, 4'h0, 4'h0);
    check("oe", oe, 4'hF);
    chk1("auto", auto, 1'b1);
    check("pins", dv & 4'hB, 4'h0);
    chk1("loop", loop, 1'b0);
    apply(1'b1, 4'h0, 4'hC);
    check("pins", dv & 4'hB, 4'h9);
    chk1("rate_pin", dv[2], 1'h1);
    chk1("loop", loop, 1'b1);
    chk1("locked", locked, 1'b1);
    // Reset in mid-run while locked: every driven pin must let go.
    rst_in = 1'h1;
    @(negedge clk_sys_in);
    check("oe", oe, 4'h0);
    check("pins", dv, 4'h0);
    chk1("locked", locked, 1'h0);
    rst_in = 1'h0;
    apply(1'b1, 4'h0, 4'hB);
    check("oe", oe, 4'hF);
    check("pins", dv & 4'hB, 4'h3);
    chk1("rate_pin", dv[2], 1'h0);
    chk1("rate_hd", rate_hd, 1'b1);
    check("mode", {2'h0, pm}, {2'h0, LMC_MODE_ASYNC});
    apply(1'b1, 4'h0, 4'h4);
    check("pins", dv & 4'hB, 4'h0);
    chk1("loop", loop, 1'b0);
    chk1("locked", locked, 1'b0);
    apply(1'b0, 4'h1, 4'h0);
    check("oe", oe, 4'h0);
    finish_test();
  end
endmodule
